// *** rtl/pdsb_bridge.sv ***
// Direct slave bridge: PCI target side, write/read FIFOs, local master.
// Assumes PCI and local pins are asynchronous; DMA signals share MCLK_I.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - I/O accesses disconnect after one transfer; single reads fetch one longword.
// - Memory reads without prefetch disconnect after the first data transfer.
// - Memory reads prefetch programmed count plus one, up to 16; unused data flushed.
// - Optional delayed read: retry first, serve data on the repeated read.
// - Three windows, each with range, remap and base; descriptor sets options.
// - Range bit n selects PCI address bit n for window decode.
// - Decoded address bits are replaced by remap bits toward local bus.
// - Base register reads zero in bits excluded by the range.
// - Separate 16 longword write FIFO and 16 longword read FIFO.
// - Write into full FIFO gets retry or TRDY wait states, as configured.
// - TRDY held off on reads until local longword is available.
// - I/O reads never prefetch; each phase is one local cycle.
// - Read TRDY holdoff counted against limit; retry on expiry.
// - A locked access locks all windows until the master releases lock.
// - Local lock asserted from address cycle until after last access.
// - Local lock released only after FRAME and LOCK both seen high.
// - Direct slave beats DMA; DMA ownership shows hold, no flag, ack.
// - Pending access makes DMA release bus within two longwords.
// - After ack low assert hold and flag; transfer once ack high.
// - After transfer drop hold and flag; resume DMA on ack low, pause zero.
module pdsb_bridge (
   // Clock and reset
   input  wire logic                    MCLK_I,
   input  wire logic                    RST_N_I,
   // Configuration port
   input  wire logic [pdsb_pkg::AW-1:0] REG_ADDR_I,
   input  wire logic [31:0]             REG_WDATA_I,
   input  wire logic                    REG_WR_I,
   input  wire logic                    REG_RD_I,
   output logic      [31:0]             REG_RDATA_O,
   // PCI target
   input  wire logic                    FRAME_N_I,
   input  wire logic                    IRDY_N_I,
   input  wire logic                    LOCK_N_I,
   input  wire logic [31:0]             AD_I,
   input  wire logic [3:0]              CBE_I,
   output logic      [31:0]             AD_O,
   output logic                         AD_OE_O,
   output logic                         TRDY_N_O,
   output logic                         STOP_N_O,
   output logic                         DEVSEL_N_O,
   // Local bus master
   output logic      [31:0]             LA_O,
   input  wire logic [31:0]             LD_I,
   output logic      [31:0]             LD_O,
   output logic                         LD_OE_O,
   output logic                         LBUS_OE_O,
   output logic                         LADS_N_O,
   output logic                         LWR_O,
   input  wire logic                    LREADY_N_I,
   output logic                         LOCAL_BUS_HOLD_REQUEST_O,
   input  wire logic                    LOCAL_BUS_HOLD_ACK_I,
   output logic                         DIRECT_SLAVE_HOLD_FLAG_O,
   output logic                         LOCAL_LOCK_OUT_N_O,
   // DMA engine
   input  wire logic                    DMA_HOLD_I,
   input  wire logic                    DMA_WORD_I,
   input  wire logic                    PAUSE_ZERO_I,
   output logic                         DMA_PAUSE_O
);
   import pdsb_pkg::*;

   logic [1:0]  frm_s, irdy_s, lck_s, rdy_s, ack_s;
   logic [31:0] ad_s1, ad_s2, ld_s1, ld_s2;
   logic [3:0]  cbe_s1, cbe_s2;
   logic        frame_n, irdy_n, lock_n, rdy_n, ack, frm_prev_q;
   logic [31:0] rng_q [NWIN];
   logic [31:0] rmp_q [NWIN];
   logic [31:0] bar_q [NWIN];
   logic [31:0] xl    [NWIN];
   logic [NWIN-1:0] hit;
   logic [31:0] desc_q, laddr, rdata_d;
   logic        pf_en, lock_en, retry_full, delay_en;
   logic [3:0]  pf_cnt;
   logic [7:0]  hold_lim, hcnt_q;
   logic [63:0] wf_mem [DEPTH];
   logic [31:0] rf_mem [DEPTH];
   logic [PW-1:0] wf_wp_q, wf_rp_q, rf_wp_q, rf_rp_q;
   logic        wf_full, wf_empty, rf_full, rf_empty;
   logic        wf_push, wf_pop, rf_push, rf_pop, rf_flush_q;
   pdsb_pci_e   p_q;
   pdsb_loc_e   l_q;
   logic [31:0] paddr_q, rd_addr_q, dly_addr_q, la_q, ld_q;
   logic [4:0]  rd_cnt_q, lcnt_q;
   logic        p_io_q, p_last_q, rd_go_q, rd_live_q, dly_pend_q;
   logic        lock_act_q, start_evt, cmd_ok, is_io, is_wr, locked;
   logic        hold_ds_q, dma_allow_q, ywc_q, lwr_q, lads_n_q, loe_q;
   logic        rd_pend_q, need, lk_q;

   // Two-flop synchronisers on all PCI and local bus pins
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         frm_s  <= 2'h3;
         irdy_s <= 2'h3;
         lck_s  <= 2'h3;
         rdy_s  <= 2'h3;
         ack_s  <= 2'h0;
         ad_s1  <= ZERO32;
         ad_s2  <= ZERO32;
         ld_s1  <= ZERO32;
         ld_s2  <= ZERO32;
         cbe_s1 <= 4'h0;
         cbe_s2 <= 4'h0;
         frm_prev_q <= 1'b1;
      end
      else
      begin
         frm_s  <= {frm_s[0], FRAME_N_I};
         irdy_s <= {irdy_s[0], IRDY_N_I};
         lck_s  <= {lck_s[0], LOCK_N_I};
         rdy_s  <= {rdy_s[0], LREADY_N_I};
         ack_s  <= {ack_s[0], LOCAL_BUS_HOLD_ACK_I};
         ad_s1  <= AD_I;
         ad_s2  <= ad_s1;
         ld_s1  <= LD_I;
         ld_s2  <= ld_s1;
         cbe_s1 <= CBE_I;
         cbe_s2 <= cbe_s1;
         frm_prev_q <= frm_s[1];
      end
   end
   assign frame_n = frm_s[1];
   assign irdy_n  = irdy_s[1];
   assign lock_n  = lck_s[1];
   assign rdy_n   = rdy_s[1];
   assign ack     = ack_s[1];

   // Per-window registers and decode
   for (genvar gw = 0; gw < NWIN; gw++)
   begin : g_win
      always_ff @(posedge MCLK_I)
      begin
         if (!RST_N_I)
         begin
            rng_q[gw] <= RANGE_RST;
            rmp_q[gw] <= ZERO32;
            bar_q[gw] <= ZERO32;
         end
         else if (REG_WR_I)
         begin
            if (REG_ADDR_I == AW'(REG_RANGE + gw))
               rng_q[gw] <= REG_WDATA_I;
            if (REG_ADDR_I == AW'(REG_REMAP + gw))
               rmp_q[gw] <= REG_WDATA_I;
            if (REG_ADDR_I == AW'(REG_BASE + gw))
               bar_q[gw] <= REG_WDATA_I;
         end
      end
      assign hit[gw] = (rng_q[gw] != ZERO32) &&
                       (((ad_s2 ^ bar_q[gw]) & rng_q[gw]) == ZERO32);
      assign xl[gw]  = (ad_s2 & ~rng_q[gw]) | (rmp_q[gw] & rng_q[gw]);
   end
   assign laddr = hit[0] ? xl[0] : (hit[1] ? xl[1] : xl[2]);

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         desc_q <= DESC_RST;
      else if (REG_WR_I && REG_ADDR_I == REG_DESC)
         desc_q <= REG_WDATA_I;
   end
   assign pf_en      = desc_q[D_PF_EN];
   assign pf_cnt     = desc_q[D_PF_LO +: 4];
   assign lock_en    = desc_q[D_LOCK_EN];
   assign retry_full = desc_q[D_RETRY];
   assign delay_en   = desc_q[D_DELAY];
   assign hold_lim   = desc_q[D_HOLD_LO +: 8];

   always_comb
   begin
      rdata_d = ZERO32;
      for (int i = 0; i < NWIN; i++)
      begin
         if (REG_ADDR_I == AW'(REG_RANGE + i))
            rdata_d = rng_q[i];
         if (REG_ADDR_I == AW'(REG_REMAP + i))
            rdata_d = rmp_q[i];
         if (REG_ADDR_I == AW'(REG_BASE + i))
            rdata_d = bar_q[i] & rng_q[i];
      end
      if (REG_ADDR_I == REG_DESC)
         rdata_d = desc_q;
      if (REG_ADDR_I == REG_STAT)
         rdata_d = {26'h0, lock_act_q, dly_pend_q, wf_full, wf_empty,
                    rf_full, rf_empty};
   end
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         REG_RDATA_O <= ZERO32;
      else
         REG_RDATA_O <= REG_RD_I ? rdata_d : ZERO32;
   end

   // Write and read FIFOs
   assign wf_empty = wf_wp_q == wf_rp_q;
   assign wf_full  = (wf_wp_q ^ wf_rp_q) == PTR_WRAP;
   assign rf_empty = rf_wp_q == rf_rp_q;
   assign rf_full  = (rf_wp_q ^ rf_rp_q) == PTR_WRAP;
   always_ff @(posedge MCLK_I)
   begin
      if (wf_push)
         wf_mem[wf_wp_q[PW-2:0]] <= {paddr_q, ad_s2};
      if (rf_push)
         rf_mem[rf_wp_q[PW-2:0]] <= ld_s2;
   end
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         wf_wp_q <= '0;
         wf_rp_q <= '0;
         rf_wp_q <= '0;
         rf_rp_q <= '0;
      end
      else
      begin
         if (wf_push)
            wf_wp_q <= wf_wp_q + PTR_ONE;
         if (wf_pop)
            wf_rp_q <= wf_rp_q + PTR_ONE;
         if (rf_push)
            rf_wp_q <= rf_wp_q + PTR_ONE;
         if (rf_flush_q)
            rf_rp_q <= rf_wp_q;
         else if (rf_pop)
            rf_rp_q <= rf_rp_q + PTR_ONE;
      end
   end

   // PCI target
   assign is_io   = cbe_s2 == CMD_IORD || cbe_s2 == CMD_IOWR;
   assign is_wr   = cbe_s2 == CMD_IOWR || cbe_s2 == CMD_MWR;
   assign cmd_ok  = is_io || cbe_s2 == CMD_MRD || cbe_s2 == CMD_MWR;
   assign locked  = lock_en && !lock_n;
   assign start_evt = p_q == P_IDLE && frm_prev_q && !frame_n && |hit && cmd_ok;
   assign wf_push = p_q == P_WR && !irdy_n && !wf_full;
   assign rf_pop  = p_q == P_RD && !irdy_n && !rf_empty;

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         p_q <= P_IDLE;
         {TRDY_N_O, STOP_N_O, DEVSEL_N_O} <= 3'h7;
         AD_O <= ZERO32;
         AD_OE_O <= 1'b0;
         paddr_q <= ZERO32;
         rd_addr_q <= ZERO32;
         dly_addr_q <= ZERO32;
         rd_cnt_q <= 5'h0;
         hcnt_q <= 8'h0;
         {p_io_q, p_last_q, rd_go_q, rd_live_q} <= 4'h0;
         {dly_pend_q, rf_flush_q} <= 2'h0;
      end
      else
      begin
         rd_go_q <= 1'b0;
         rf_flush_q <= 1'b0;
         unique case (p_q)
            P_IDLE:
            begin
               {TRDY_N_O, STOP_N_O, DEVSEL_N_O} <= 3'h7;
               AD_OE_O <= 1'b0;
               hcnt_q <= 8'h0;
               if (start_evt)
               begin
                  DEVSEL_N_O <= 1'b0;
                  paddr_q <= laddr;
                  p_io_q <= is_io;
                  if (lock_act_q && !locked)
                     p_q <= P_STOP;
                  else if (is_wr)
                     p_q <= P_WR;
                  else if (delay_en && dly_pend_q && dly_addr_q == laddr)
                     p_q <= P_RD;
                  else
                  begin
                     if (!(delay_en && dly_pend_q))
                     begin
                        rd_go_q <= 1'b1;
                        rd_live_q <= 1'b1;
                        rd_addr_q <= laddr;
                        rd_cnt_q <= (is_io || !pf_en) ? 5'h1 :
                                    {1'b0, pf_cnt} + 5'h1;
                        dly_addr_q <= laddr;
                        dly_pend_q <= delay_en;
                     end
                     p_q <= delay_en ? P_STOP : P_RD;
                  end
               end
            end
            P_WR:
            begin
               p_last_q <= frame_n;
               if (wf_push)
               begin
                  TRDY_N_O <= 1'b0;
                  p_q <= P_WACK;
               end
               else if (!irdy_n && retry_full)
                  p_q <= P_STOP;
            end
            P_WACK:
            begin
               TRDY_N_O <= 1'b1;
               paddr_q <= paddr_q + LW_STEP;
               if (p_last_q)
                  p_q <= P_IDLE;
               else if (p_io_q)
                  p_q <= P_STOP;
               else
                  p_q <= P_WR;
            end
            P_RD:
            begin
               hcnt_q <= hcnt_q + 8'h1;
               p_last_q <= frame_n;
               if (rf_pop)
               begin
                  AD_O <= rf_mem[rf_rp_q[PW-2:0]];
                  AD_OE_O <= 1'b1;
                  TRDY_N_O <= 1'b0;
                  hcnt_q <= 8'h0;
                  dly_pend_q <= 1'b0;
                  p_q <= P_RACK;
               end
               else if (hcnt_q == hold_lim)
                  p_q <= P_STOP;
            end
            P_RACK:
            begin
               TRDY_N_O <= 1'b1;
               if (p_last_q)
               begin
                  p_q <= P_IDLE;
                  rf_flush_q <= 1'b1;
                  rd_live_q <= 1'b0;
               end
               else if (p_io_q || !pf_en)
                  p_q <= P_STOP;
               else
                  p_q <= P_RD;
            end
            P_STOP:
            begin
               STOP_N_O <= 1'b0;
               TRDY_N_O <= 1'b1;
               AD_OE_O <= 1'b0;
               if (frame_n)
               begin
                  p_q <= P_IDLE;
                  if (!dly_pend_q)
                  begin
                     rf_flush_q <= 1'b1;
                     rd_live_q <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         lock_act_q <= 1'b0;
      else if (frame_n && lock_n)
         lock_act_q <= 1'b0;
      else if (start_evt && locked)
         lock_act_q <= 1'b1;
   end

   // Local bus master and arbitration with DMA
   assign need = !wf_empty || (rd_pend_q && rd_live_q);
   assign wf_pop = l_q == L_REQ && ack && !wf_empty;
   assign rf_push = l_q == L_DATA && !rdy_n && !lwr_q && rd_live_q && !rf_flush_q;

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         l_q <= L_IDLE;
         {hold_ds_q, ywc_q, lwr_q, loe_q, rd_pend_q} <= 5'h0;
         dma_allow_q <= 1'b1;
         lads_n_q <= 1'b1;
         la_q <= ZERO32;
         ld_q <= ZERO32;
         lcnt_q <= 5'h0;
      end
      else
      begin
         if (rd_go_q)
            rd_pend_q <= 1'b1;
         unique case (l_q)
            L_IDLE:
               if (need)
               begin
                  ywc_q <= 1'b0;
                  if (DMA_HOLD_I && dma_allow_q && ack)
                     l_q <= L_YIELD;
                  else
                  begin
                     dma_allow_q <= 1'b0;
                     l_q <= L_WLOW;
                  end
               end
            L_YIELD:
            begin
               if (DMA_WORD_I)
                  ywc_q <= 1'b1;
               if (!DMA_HOLD_I || (DMA_WORD_I && ywc_q))
               begin
                  dma_allow_q <= 1'b0;
                  l_q <= L_WLOW;
               end
            end
            L_WLOW:
               if (!ack)
               begin
                  hold_ds_q <= 1'b1;
                  l_q <= L_REQ;
               end
            L_REQ:
               if (ack)
               begin
                  loe_q <= 1'b1;
                  lads_n_q <= 1'b0;
                  l_q <= L_ADDR;
                  if (!wf_empty)
                  begin
                     la_q <= wf_mem[wf_rp_q[PW-2:0]][63:32];
                     ld_q <= wf_mem[wf_rp_q[PW-2:0]][31:0];
                     lwr_q <= 1'b1;
                  end
                  else
                  begin
                     la_q <= rd_addr_q;
                     lwr_q <= 1'b0;
                     lcnt_q <= rd_cnt_q;
                     rd_pend_q <= rd_go_q;
                  end
               end
            L_ADDR:
            begin
               lads_n_q <= 1'b1;
               l_q <= L_DATA;
            end
            L_DATA:
               if (!rdy_n)
               begin
                  la_q <= la_q + LW_STEP;
                  lcnt_q <= lcnt_q - 5'h1;
                  if (!lwr_q && lcnt_q > 5'h1 && rd_live_q && !rf_full)
                  begin
                     lads_n_q <= 1'b0;
                     l_q <= L_ADDR;
                  end
                  else if (lwr_q && !wf_empty)
                  begin
                     la_q <= wf_mem[wf_rp_q[PW-2:0]][63:32];
                     ld_q <= wf_mem[wf_rp_q[PW-2:0]][31:0];
                     lads_n_q <= 1'b0;
                     l_q <= L_ADDR;
                  end
                  else
                  begin
                     hold_ds_q <= 1'b0;
                     loe_q <= 1'b0;
                     l_q <= L_REL;
                  end
               end
            L_REL:
               if (!ack && PAUSE_ZERO_I)
               begin
                  dma_allow_q <= 1'b1;
                  l_q <= L_IDLE;
               end
         endcase
      end
   end

   // Lock holds from the first address cycle until the PCI side lets go
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         lk_q <= 1'b0;
      else if (l_q == L_ADDR && lock_act_q)
         lk_q <= 1'b1;
      else if (!lock_act_q && l_q != L_ADDR && l_q != L_DATA)
         lk_q <= 1'b0;
   end
   assign LOCAL_LOCK_OUT_N_O = !(lk_q || (l_q == L_ADDR && lock_act_q));

   assign LOCAL_BUS_HOLD_REQUEST_O = hold_ds_q || (DMA_HOLD_I && dma_allow_q);
   assign DIRECT_SLAVE_HOLD_FLAG_O = hold_ds_q;
   assign DMA_PAUSE_O = !dma_allow_q || l_q == L_YIELD;
   assign LA_O      = la_q;
   assign LD_O      = ld_q;
   assign LD_OE_O   = loe_q && lwr_q;
   assign LBUS_OE_O = loe_q;
   assign LADS_N_O  = lads_n_q;
   assign LWR_O     = lwr_q;
endmodule
`default_nettype wire

// *** inc/pdsb_pkg.sv ***
// Constants and types of the direct slave bridge.
// Shared by the bridge and its bench; no other dependency.
package pdsb_pkg;
   localparam int AW    = 4;
   localparam int NWIN  = 3;
   localparam int DEPTH = 16;
   localparam int PW    = 5;
   // Register indices
   localparam logic [AW-1:0] REG_RANGE = 4'h0;
   localparam logic [AW-1:0] REG_REMAP = 4'h3;
   localparam logic [AW-1:0] REG_BASE  = 4'h6;
   localparam logic [AW-1:0] REG_DESC  = 4'h9;
   localparam logic [AW-1:0] REG_STAT  = 4'hA;
   // Descriptor fields
   localparam int D_PF_EN   = 0;
   localparam int D_PF_LO   = 1;
   localparam int D_LOCK_EN = 5;
   localparam int D_RETRY   = 6;
   localparam int D_DELAY   = 7;
   localparam int D_HOLD_LO = 8;
   localparam logic [31:0] DESC_RST  = 32'h0000_FF1F;
   localparam logic [31:0] RANGE_RST = 32'h0000_0000;
   localparam logic [31:0] ZERO32    = 32'h0000_0000;
   localparam logic [31:0] LW_STEP   = 32'h0000_0004;
   // PCI commands
   localparam logic [3:0] CMD_IORD = 4'h2;
   localparam logic [3:0] CMD_IOWR = 4'h3;
   localparam logic [3:0] CMD_MRD  = 4'h6;
   localparam logic [3:0] CMD_MWR  = 4'h7;
   localparam logic [PW-1:0] PTR_ONE  = 5'h01;
   localparam logic [PW-1:0] PTR_WRAP = 5'h10;
   typedef enum logic [2:0] {
      P_IDLE, P_WR, P_WACK, P_RD, P_RACK, P_STOP
   } pdsb_pci_e;
   typedef enum logic [2:0] {
      L_IDLE, L_YIELD, L_WLOW, L_REQ, L_ADDR, L_DATA, L_REL
   } pdsb_loc_e;
endpackage

// *** sim/pdsb_chk.sv ***
// Port checker for the direct slave bridge.
// Bound into every bridge instance; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module pdsb_chk (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // PCI side
   input wire logic FRAME_N_I,
   input wire logic LOCK_N_I,
   input wire logic TRDY_N_O,
   input wire logic DEVSEL_N_O,
   // Local side
   input wire logic LADS_N_O,
   input wire logic LBUS_OE_O,
   input wire logic LOCAL_BUS_HOLD_REQUEST_O,
   input wire logic DIRECT_SLAVE_HOLD_FLAG_O,
   input wire logic LOCAL_LOCK_OUT_N_O,
   input wire logic PAUSE_ZERO_I,
   input wire logic DMA_PAUSE_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   a_flag_with_hold: assert property (DIRECT_SLAVE_HOLD_FLAG_O |->
      LOCAL_BUS_HOLD_REQUEST_O) else $error("flag without hold request");
   a_flag_pauses_dma: assert property (DIRECT_SLAVE_HOLD_FLAG_O |->
      DMA_PAUSE_O) else $error("dma not paused during direct slave");
   a_strobe_one_clk: assert property (!LADS_N_O |=> LADS_N_O)
      else $error("address strobe longer than one clock");
   a_strobe_owned: assert property (!LADS_N_O |->
      LBUS_OE_O && DIRECT_SLAVE_HOLD_FLAG_O) else $error("strobe without bus");
   a_lock_at_addr: assert property ($fell(LOCAL_LOCK_OUT_N_O) |->
      !LADS_N_O) else $error("local lock not in address cycle");
   a_lock_outlasts: assert property (!LADS_N_O && !LOCAL_LOCK_OUT_N_O |=>
      !LOCAL_LOCK_OUT_N_O) else $error("local lock dropped too early");
   a_lock_release: assert property ($rose(LOCAL_LOCK_OUT_N_O) |->
      $past(FRAME_N_I, 2) && $past(LOCK_N_I, 2)) else $error("lock freed early");
   a_trdy_claimed: assert property (!TRDY_N_O |-> !DEVSEL_N_O)
      else $error("target ready without device select");
   a_resume_gated: assert property ($fell(DMA_PAUSE_O) |->
      $past(PAUSE_ZERO_I) && !DIRECT_SLAVE_HOLD_FLAG_O) else $error("dma resumed early");
endmodule
bind pdsb_bridge pdsb_chk chk_u (.*);
`default_nettype wire

// *** sim/pdsb_local_model.sv ***
// Local arbiter and memory facing the bridge's local master port.
// Single other master; ready comes wait_i + 1 clocks after each strobe.
`timescale 1ns/1ns
`default_nettype none
module pdsb_local_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Local bus
   input  wire logic        hold_i,
   input  wire logic        lads_n_i,
   input  wire logic        lwr_i,
   input  wire logic [31:0] la_i,
   input  wire logic [31:0] ld_i,
   input  wire logic [7:0]  wait_i,
   output logic             ack_o,
   output logic             rdy_n_o,
   output logic [31:0]      rd_o
);
   logic [31:0] mem [16];
   logic [31:0] last_la;
   logic [7:0]  cnt;
   logic        busy;
   int          n_ads;
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ack_o <= 1'b0;
         rdy_n_o <= 1'b1;
         busy <= 1'b0;
         n_ads <= 0;
         rd_o <= 32'h0000_0000;
      end
      else
      begin
         // Grant follows hold; no rival master, so a lock is always kept
         ack_o <= hold_i;
         rdy_n_o <= 1'b1;
         rd_o <= ~rd_o;
         if (!lads_n_i)
         begin
            busy <= 1'b1;
            cnt <= 8'h00;
            last_la <= la_i;
            n_ads <= n_ads + 1;
         end
         else if (busy)
         begin
            cnt <= cnt + 8'h01;
            if (cnt >= wait_i)
            begin
               rdy_n_o <= 1'b0;
               busy <= 1'b0;
               if (lwr_i)
                  mem[last_la[5:2]] <= ld_i;
               else
                  rd_o <= mem[last_la[5:2]];
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Bench for the direct slave bridge: register port, PCI initiator, DMA.
// Local side is answered by the local model.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pdsb_pkg::*;
   logic        clk, rst_n, wr, rd, frame, irdy, lock, dhold, dword, pz;
   logic        hreq, ack, flag, lk_n, pause, trdy_n, stop_n, lads_n, lwr;
   logic        rdy_n, oe, got, st, lo;
   logic [3:0]  ra, cbe;
   logic [31:0] wd, rdata, ad, ad_o, la, ld, ldl, rdat;
   logic [7:0]  wt;
   int          n_fail, tests_run, k, n0;
   pdsb_bridge dut_u (.MCLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(ra), .REG_WDATA_I(wd),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FRAME_N_I(frame),
      .IRDY_N_I(irdy), .LOCK_N_I(lock), .AD_I(ad), .CBE_I(cbe), .AD_O(ad_o),
      .AD_OE_O(), .TRDY_N_O(trdy_n), .STOP_N_O(stop_n), .DEVSEL_N_O(), .LA_O(la),
      .LD_I(ldl), .LD_O(ld), .LD_OE_O(), .LBUS_OE_O(oe), .LADS_N_O(lads_n),
      .LWR_O(lwr), .LREADY_N_I(rdy_n), .LOCAL_BUS_HOLD_REQUEST_O(hreq),
      .LOCAL_BUS_HOLD_ACK_I(ack), .DIRECT_SLAVE_HOLD_FLAG_O(flag),
      .LOCAL_LOCK_OUT_N_O(lk_n), .DMA_HOLD_I(dhold), .DMA_WORD_I(dword),
      .PAUSE_ZERO_I(pz), .DMA_PAUSE_O(pause));
   pdsb_local_model lm (.clk_i(clk), .rst_n_i(rst_n), .hold_i(hreq), .lads_n_i(lads_n),
      .lwr_i(lwr), .la_i(la), .ld_i(ld), .wait_i(wt), .ack_o(ack), .rdy_n_o(rdy_n),
      .rd_o(ldl));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         n_fail++;
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rchk(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("register", e, rdata);
   endtask
   // One data phase; reads keep FRAME low so the target must disconnect
   task pci(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d, input logic l);
      @(posedge clk);
      frame <= 1'b0;
      ad <= a;
      cbe <= c;
      lock <= l;
      @(posedge clk);
      frame <= c[0];
      irdy <= 1'b0;
      ad <= d;
      got = 1'b0;
      st = 1'b0;
      lo = 1'b0;
      repeat (300)
      begin
         @(posedge clk);
         if (!got && !irdy && trdy_n === 1'b0)
         begin
            got = 1'b1;
            rdat = ad_o;
         end
         if (stop_n === 1'b0)
            st = 1'b1;
         if (lk_n === 1'b0)
            lo = 1'b1;
         if (got || st)
            {frame, irdy} <= 2'h3;
      end
      lock <= 1'b1;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run;
   end
   initial
   begin
      {rst_n, wr, rd, dword, dhold, ad, cbe, ra, wd} = '0;
      {frame, irdy, lock, pz} = 4'hF;
      wt = 8'h01;
      n_fail = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(REG_DESC, DESC_RST);
      rchk(REG_RANGE, RANGE_RST);
      rchk(4'hF, ZERO32);
      wreg(REG_RANGE, 32'hFFF0_0000);
      wreg(REG_BASE, 32'hFFFF_FFFF);
      rchk(REG_BASE, 32'hFFF0_0000);
      wreg(REG_BASE, 32'h7890_0000);
      wreg(REG_REMAP, 32'h1230_0000);
      wreg(REG_RANGE + 4'h1, 32'hFFFF_FF00);
      wreg(REG_BASE + 4'h1, 32'h0000_1000);
      wreg(REG_REMAP + 4'h1, 32'h1230_0000);
      wreg(REG_DESC, 32'h0000_FF00);
      pci(CMD_MWR, 32'h7890_0010, 32'hA5A5_0001, 1'b1);
      chk("local address", 32'h1230_0010, lm.last_la);
      n0 = lm.n_ads;
      pci(CMD_MRD, 32'h7890_0010, ZERO32, 1'b1);
      chk("read data", 32'hA5A5_0001, rdat);
      chk("read disconnect", 32'h1, st);
      chk("single fetch", n0 + 1, lm.n_ads);
      wreg(REG_DESC, 32'h0000_FF07);
      n0 = lm.n_ads;
      pci(CMD_IORD, 32'h0000_1010, ZERO32, 1'b1);
      chk("io data", 32'hA5A5_0001, rdat);
      chk("io disconnect", 32'h1, st);
      chk("io fetch", n0 + 1, lm.n_ads);
      n0 = lm.n_ads;
      pci(CMD_MRD, 32'h7890_0010, ZERO32, 1'b1);
      chk("prefetch count", n0 + 4, lm.n_ads);
      wreg(REG_DESC, 32'h0000_FF20);
      pci(CMD_MRD, 32'h7890_0010, ZERO32, 1'b0);
      chk("lock asserted", 32'h1, lo);
      repeat (8) @(posedge clk);
      chk("lock released", 32'h1, lk_n);
      wreg(REG_DESC, 32'h0000_FF00);
      pci(CMD_MRD, 32'h7890_0010, ZERO32, 1'b0);
      chk("lock ignored", 32'h0, lo);
      wreg(REG_DESC, 32'h0000_FF80);
      pci(CMD_MRD, 32'h7890_0010, ZERO32, 1'b1);
      chk("delayed retry", 32'h1, st && !got);
      pci(CMD_MRD, 32'h7890_0010, ZERO32, 1'b1);
      chk("delayed data", 32'hA5A5_0001, rdat);
      wreg(REG_DESC, 32'h0000_0800);
      wt <= 8'h28;
      pci(CMD_MRD, 32'h7890_0010, ZERO32, 1'b1);
      chk("holdoff retry", 32'h1, st && !got);
      wt <= 8'h01;
      wreg(REG_DESC, 32'h0000_FF00);
      pz <= 1'b0;
      dhold <= 1'b1;
      repeat (6) @(posedge clk);
      fork
         pci(CMD_MWR, 32'h7890_0014, 32'h0000_5A5A, 1'b1);
         begin
            k = 0; while (pause !== 1'b1 && k < 40) begin @(posedge clk); k++; end
            repeat (2) begin @(posedge clk) dword <= 1'b1; @(posedge clk) dword <= 1'b0; end
            k = 0; while (hreq !== 1'b0 && k < 4) begin @(posedge clk); k++; end
            chk("dma yields", 32'h0, hreq);
            k = 0; while (flag !== 1'b1 && k < 40) begin @(posedge clk); k++; end
            chk("slave hold", 32'h1, hreq && flag);
            k = 0; while (flag !== 1'b0 && k < 80) begin @(posedge clk); k++; end
            chk("slave release", 32'h0, hreq || oe);
            pz <= 1'b1;
            k = 0; while (pause !== 1'b0 && k < 20) begin @(posedge clk); k++; end
            chk("dma resumed", 32'h0, pause);
         end
      join
      dhold <= 1'b0;
      complete_run;
   end
endmodule
`default_nettype wire
